// ==== rtl/mmd_map.vh ====
// Behaviour
// - Decode one linear 16 Mbyte space, byte/word.
// - User mode flash blocks at fixed ranges.
// - Bootstrap shows 8K test block at zero.
// - Never read the bank being modified.
// - Two flash banks, 384K and 128K.
// - Extension RAM 16-bit, zero waits, byte/word.
// - Area one decoded when global and bit2 set.
// - Disabled area one goes to external interface.
// - Area two at F0000h with global and bit3.
// - CAN A window needs global and bit0.
// - CAN B window needs global and bit1.
// - Clock window needs global and bit4.
// - Extra PWM window needs global and bit6.
// - Async serial B needs global and bit7.
// - Sync serial B needs global and bit8.
// - I2C window needs global and bit9.
// - Misc window needs global and bit10.
// - Peripheral windows word only, two waits.
// - CAN in use limits segment lines to four.
// - Disabled peripheral claims no space at all.
// - Flash fetch 32-bit, data 16-bit, control 16-bit.
`ifndef MMD_MAP_VH
`define MMD_MAP_VH

// --------------------------------------------------------------------------
// Address field positions and region bases.
// --------------------------------------------------------------------------
`define MMD_AW 24
`define MMD_FLASH_BASE 24'h000000
`define MMD_FLASH_LAST 24'h08ffff
`define MMD_TEST_LAST 24'h001fff
`define MMD_LOW_FLASH_LAST 24'h007fff
`define MMD_MID_FLASH_BASE 24'h018000
`define MMD_BANK1_BASE 24'h070000
`define MMD_FCTL_BASE 24'h0e0000
`define MMD_FCTL_LAST 24'h0effff
`define MMD_XR1_BASE 24'h00e000
`define MMD_XR1_LAST 24'h00e7ff
`define MMD_XR2_BASE 24'h0f0000
`define MMD_XR2_LAST 24'h0f7fff
`define MMD_PWIN_HI 24'h00efff
`define MMD_PWIN_LO 24'h00e800
`define MMD_PAGE_HI 15
`define MMD_PAGE_LO 8
`define MMD_PG_SSCB 8'he8
`define MMD_PG_ASCB 8'he9
`define MMD_PG_I2C 8'hea
`define MMD_PG_MISC 8'heb
`define MMD_PG_PWM 8'hec
`define MMD_PG_RTC 8'hed
`define MMD_PG_CANB 8'hee
`define MMD_PG_CANA 8'hef

// --------------------------------------------------------------------------
// Enable bit positions.
// --------------------------------------------------------------------------
`define MMD_SYS_XPE_BIT 2
`define MMD_PE_CANA 0
`define MMD_PE_CANB 1
`define MMD_PE_XR1 2
`define MMD_PE_XR2 3
`define MMD_PE_RTC 4
`define MMD_PE_PWM 6
`define MMD_PE_ASCB 7
`define MMD_PE_SSCB 8
`define MMD_PE_I2C 9
`define MMD_PE_MISC 10

// --------------------------------------------------------------------------
// Target codes, widths and wait states.
// --------------------------------------------------------------------------
`define MMD_T_EXT 4'h0
`define MMD_T_FLASH0 4'h1
`define MMD_T_FLASH1 4'h2
`define MMD_T_TEST 4'h3
`define MMD_T_FCTL 4'h4
`define MMD_T_XR1 4'h5
`define MMD_T_XR2 4'h6
`define MMD_T_CANA 4'h7
`define MMD_T_CANB 4'h8
`define MMD_T_RTC 4'h9
`define MMD_T_PWM 4'ha
`define MMD_T_ASCB 4'hb
`define MMD_T_SSCB 4'hc
`define MMD_T_I2C 4'hd
`define MMD_T_MISC 4'he
`define MMD_W32 2'h2
`define MMD_W16 2'h1
`define MMD_WAIT_PERIPH 2'h2
`define MMD_WAIT_NONE 2'h0
`define MMD_SEG_FULL 4'h8
`define MMD_SEG_CAN 4'h4

`endif

// ==== rtl/mmd_decoder.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mmd_map.vh"

module mmd_decoder (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire req_in,
    input wire [23:0] addr_in,
    input wire fetch_in,
    input wire write_in,
    input wire byte_in,
    input wire bootstrap_in,
    input wire [15:0] system_config_reg_in,
    input wire [15:0] periph_enable_reg_in,
    input wire bank0_busy_in,
    input wire bank1_busy_in,
    output reg valid_out,
    output reg [3:0] target_out,
    output reg [1:0] width_out,
    output reg [1:0] wait_states_out,
    output reg external_out,
    output reg size_error_out,
    output reg bank_conflict_out,
    output reg [3:0] seg_lines_out,
    output reg global_periph_enable_out
);

    // ----------------------------------------------------------------------
    // Address map overview.
    // ----------------------------------------------------------------------
    // The core issues a 24-bit byte address in each cycle that it requests.
    // This block only decides where that access goes and how it is shaped;
    // it moves no data and keeps no memory of earlier accesses.
    //
    // Regions, from the highest priority down:
    //   - Peripheral zone 00e800h..00efffh, split into eight 256-byte pages.
    //     A page answers only with the global enable and its own enable set.
    //   - Extension RAM area one, 00e000h..00e7ffh, 2K.
    //   - Extension RAM area two, 0f0000h..0f7fffh, 32K.
    //   - Flash control area, 0e0000h..0effffh, always on chip.
    //   - Test flash block, 000000h..001fffh, in bootstrap mode only.
    //   - Program flash: four 8K blocks from zero, then 018000h..08ffffh.
    //     Bank one starts at 070000h; everything below it is bank zero.
    //   - Anything else goes to the external memory interface.
    //
    // Only the test block overlaps the program flash, so the priority order
    // matters there alone; elsewhere it follows the order in which a reader scans the map.
    //
    // Limitations a user must know:
    //   - The gap 008000h..017fffh is not flash in user mode; outside 00e000h..00efffh it goes out.
    //   - Only the bottom 8K is replaced by the test block in bootstrap;
    //     the other low blocks still read as user flash.
    //   - Byte accesses to a peripheral page are flagged, not blocked; the
    //     bus interface downstream has to turn the flag into a trap.
    //   - A read of a busy flash bank is flagged the same way. Writes pass,
    //     since the erase controller itself owns the write path.
    //
    // Every output is registered, so the answer to a request sampled on one
    // edge appears after that edge and stands for one cycle.

    // ----------------------------------------------------------------------
    // Helper functions.
    // ----------------------------------------------------------------------

    // Inclusive window test on a full byte address. Every region is a
    // closed range, so both ends are compared instead of masking high bits;
    // that keeps odd-sized regions such as the 018000h..08ffffh flash range exact.
    function in_range;
        input [`MMD_AW-1:0] a;
        input [`MMD_AW-1:0] lo;
        input [`MMD_AW-1:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // Maps one page of the peripheral zone to its target code. A window
    // whose own enable is clear claims no space, so the access is handed to
    // the external interface exactly as if no peripheral were present.
    // The global enable is applied by the caller, not here.
    function [3:0] window_target;
        input [7:0] pg;
        input [15:0] en;
        begin
            window_target = `MMD_T_EXT;
            case (pg)
                `MMD_PG_CANA: begin
                    if (en[`MMD_PE_CANA]) begin
                        window_target = `MMD_T_CANA;
                    end
                end
                `MMD_PG_CANB: begin
                    if (en[`MMD_PE_CANB]) begin
                        window_target = `MMD_T_CANB;
                    end
                end
                `MMD_PG_RTC: begin
                    if (en[`MMD_PE_RTC]) begin
                        window_target = `MMD_T_RTC;
                    end
                end
                `MMD_PG_PWM: begin
                    if (en[`MMD_PE_PWM]) begin
                        window_target = `MMD_T_PWM;
                    end
                end
                `MMD_PG_ASCB: begin
                    if (en[`MMD_PE_ASCB]) begin
                        window_target = `MMD_T_ASCB;
                    end
                end
                `MMD_PG_SSCB: begin
                    if (en[`MMD_PE_SSCB]) begin
                        window_target = `MMD_T_SSCB;
                    end
                end
                `MMD_PG_I2C: begin
                    if (en[`MMD_PE_I2C]) begin
                        window_target = `MMD_T_I2C;
                    end
                end
                `MMD_PG_MISC: begin
                    if (en[`MMD_PE_MISC]) begin
                        window_target = `MMD_T_MISC;
                    end
                end
                default: begin
                    window_target = `MMD_T_EXT;
                end
            endcase
        end
    endfunction

    // True for the eight peripheral page targets. They share one bus shape,
    // so the attribute logic asks this once instead of listing the codes in
    // several places where one could be missed.
    function is_window;
        input [3:0] t;
        begin
            case (t)
                `MMD_T_CANA, `MMD_T_CANB, `MMD_T_RTC, `MMD_T_PWM,
                `MMD_T_ASCB, `MMD_T_SSCB, `MMD_T_I2C, `MMD_T_MISC: begin
                    is_window = 1'h1;
                end
                default: begin
                    is_window = 1'h0;
                end
            endcase
        end
    endfunction

    // True for every target that reads the flash array. The test block is
    // counted here since it lives in bank zero beside the user blocks.
    // The control area is not array storage and stays out.
    function is_flash;
        input [3:0] t;
        begin
            case (t)
                `MMD_T_FLASH0, `MMD_T_FLASH1, `MMD_T_TEST: begin
                    is_flash = 1'h1;
                end
                default: begin
                    is_flash = 1'h0;
                end
            endcase
        end
    endfunction

    // Picks the bank of a user flash address. Only the split point matters
    // here; the result is worked out for every address but chosen only when the
    // address is inside the array, so the gap above the 32K block never reaches the output.
    function [3:0] flash_bank_target;
        input [`MMD_AW-1:0] a;
        begin
            if (a >= `MMD_BANK1_BASE) begin
                flash_bank_target = `MMD_T_FLASH1;
            end else begin
                flash_bank_target = `MMD_T_FLASH0;
            end
        end
    endfunction

    // Busy state of the bank behind a flash target. Each bank has its own
    // sense amplifiers, so only a read of the bank under modification is flagged and
    // the other one stays readable at full speed.
    function bank_busy;
        input [3:0] t;
        input busy0;
        input busy1;
        begin
            if (t == `MMD_T_FLASH1) begin
                bank_busy = busy1;
            end else begin
                bank_busy = busy0;
            end
        end
    endfunction

    // ----------------------------------------------------------------------
    // Decode.
    // ----------------------------------------------------------------------

    reg [3:0] tgt_d;
    reg [1:0] width_d;
    reg [1:0] wait_d;
    reg size_err_d;
    reg conflict_d;
    wire xpe;
    wire [7:0] page;
    wire periph_zone;
    wire xr1_zone;
    wire xr2_zone;
    wire fctl_zone;
    wire test_zone;
    wire flash_zone;
    wire xr1_on;
    wire xr2_on;
    wire any_can;
    wire [3:0] win_tgt;
    wire [3:0] flash_tgt;

    // Global enable and the page field of the peripheral zone.
    assign xpe = system_config_reg_in[`MMD_SYS_XPE_BIT];
    assign page = addr_in[`MMD_PAGE_HI:`MMD_PAGE_LO];

    // Raw region hits, independent of any enable. Keeping the ranges apart
    // from the enables lets a disabled region fall cleanly through to the
    // external interface instead of being caught by a later test.
    assign periph_zone = in_range(addr_in, `MMD_PWIN_LO, `MMD_PWIN_HI);
    assign xr1_zone = in_range(addr_in, `MMD_XR1_BASE, `MMD_XR1_LAST);
    assign xr2_zone = in_range(addr_in, `MMD_XR2_BASE, `MMD_XR2_LAST);
    assign fctl_zone = in_range(addr_in, `MMD_FCTL_BASE, `MMD_FCTL_LAST);
    // Bootstrap only swaps the bottom 8K; the user array keeps its holes.
    assign test_zone = bootstrap_in &&
        in_range(addr_in, `MMD_FLASH_BASE, `MMD_TEST_LAST);
    assign flash_zone = in_range(addr_in, `MMD_FLASH_BASE, `MMD_LOW_FLASH_LAST) ||
        in_range(addr_in, `MMD_MID_FLASH_BASE, `MMD_FLASH_LAST);

    // Each RAM area needs the global enable and its own bit. With either
    // clear the range belongs to whatever the external select windows put
    // there, so no on-chip target is chosen.
    assign xr1_on = xpe && periph_enable_reg_in[`MMD_PE_XR1];
    assign xr2_on = xpe && periph_enable_reg_in[`MMD_PE_XR2];

    // A CAN window held open takes port lines that would carry segment bits.
    assign any_can = xpe && (periph_enable_reg_in[`MMD_PE_CANA] ||
        periph_enable_reg_in[`MMD_PE_CANB]);

    // Candidate targets inside the peripheral zone and the flash array.
    // They are worked out in parallel and chosen by the priority chain.
    assign win_tgt = window_target(page, periph_enable_reg_in);
    assign flash_tgt = flash_bank_target(addr_in);

    // Priority: peripheral windows, then RAM areas, then flash control,
    // then the test block, then the user array, else external. A RAM area with
    // its enable clear, or a page with its own bit clear, ends its branch with
    // the external code, so nothing further down can claim an address that the core meant to send out.
    always @* begin
        tgt_d = `MMD_T_EXT;
        if (periph_zone && xpe) begin
            tgt_d = win_tgt;
        end else if (xr1_zone) begin
            if (xr1_on) begin
                tgt_d = `MMD_T_XR1;
            end else begin
                tgt_d = `MMD_T_EXT;
            end
        end else if (xr2_zone) begin
            if (xr2_on) begin
                tgt_d = `MMD_T_XR2;
            end else begin
                tgt_d = `MMD_T_EXT;
            end
        end else if (fctl_zone) begin
            tgt_d = `MMD_T_FCTL;
        end else if (test_zone) begin
            tgt_d = `MMD_T_TEST;
        end else if (flash_zone) begin
            tgt_d = flash_tgt;
        end else begin
            tgt_d = `MMD_T_EXT;
        end
    end

    // Widths, waits and size checks per target. Anything that is neither
    // flash nor a peripheral page is a plain 16-bit access with no waits:
    // that covers both RAM areas, the control area and the external path,
    // whose own wait states are set by the external select windows.
    always @* begin
        width_d = `MMD_W16;
        wait_d = `MMD_WAIT_NONE;
        size_err_d = 1'h0;
        conflict_d = 1'h0;
        if (is_flash(tgt_d)) begin
            if (fetch_in) begin
                width_d = `MMD_W32;
            end else begin
                width_d = `MMD_W16;
            end
            conflict_d = ~write_in & bank_busy(tgt_d, bank0_busy_in, bank1_busy_in);
        end else if (is_window(tgt_d)) begin
            wait_d = `MMD_WAIT_PERIPH;
            size_err_d = byte_in;
        end else begin
            width_d = `MMD_W16;
            wait_d = `MMD_WAIT_NONE;
        end
    end

    // ----------------------------------------------------------------------
    // Registered outputs.
    // ----------------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            valid_out <= 1'b0;
            target_out <= `MMD_T_EXT;
            width_out <= `MMD_W16;
            wait_states_out <= `MMD_WAIT_NONE;
            external_out <= 1'b0;
            size_error_out <= 1'b0;
            bank_conflict_out <= 1'b0;
            seg_lines_out <= `MMD_SEG_FULL;
            global_periph_enable_out <= 1'b0;
        end else begin
            valid_out <= req_in;
            target_out <= tgt_d;
            width_out <= width_d;
            wait_states_out <= wait_d;
            external_out <= req_in && (tgt_d == `MMD_T_EXT);
            size_error_out <= req_in && size_err_d;
            bank_conflict_out <= req_in && conflict_d;
            seg_lines_out <= any_can ? `MMD_SEG_CAN : `MMD_SEG_FULL;
            global_periph_enable_out <= xpe;
        end
    end

endmodule // mmd_decoder
`default_nettype wire

// ==== verification/mmd_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Routing checks
// ----
module mmd_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic [23:0] addr_in,
    input wire logic byte_in,
    input wire logic bootstrap_in,
    input wire logic [15:0] system_config_reg_in,
    input wire logic [15:0] periph_enable_reg_in,
    input wire logic valid_out,
    input wire logic [3:0] target_out,
    input wire logic [1:0] width_out,
    input wire logic [1:0] wait_states_out,
    input wire logic external_out,
    input wire logic size_error_out,
    input wire logic [3:0] seg_lines_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Request qualifiers; enables are read straight off the inputs.
    wire gpe = system_config_reg_in[2];
    wire xr1 = req_in && addr_in >= 24'h00e000 && addr_in <= 24'h00e7ff;
    wire cana = req_in && addr_in[23:8] == 16'h00ef;
    chk_xr1_route: assert property (
        xr1 && gpe && periph_enable_reg_in[2] |=> target_out == 4'h5) else $error("ram one");
    chk_xr1_extern: assert property (
        xr1 && !(gpe && periph_enable_reg_in[2]) |=> external_out) else $error("ram one ext");
    chk_xr2_route: assert property (
        req_in && addr_in[23:15] == 9'h01e && gpe && periph_enable_reg_in[3]
        |=> target_out == 4'h6) else $error("ram two");
    chk_cana_win: assert property (
        cana && gpe && periph_enable_reg_in[0] |=> target_out == 4'h7) else $error("can a");
    chk_cana_off: assert property (
        cana && !periph_enable_reg_in[0] |=> external_out) else $error("can a off");
    chk_word_only: assert property (
        valid_out && target_out > 4'h6 |-> wait_states_out == 2'h2 && width_out == 2'h1
        && size_error_out == $past(byte_in)) else $error("window access");
    chk_boot_block: assert property (
        req_in && bootstrap_in && addr_in < 24'h002000 |=> target_out == 4'h3) else $error("boot");
    chk_seg_limit: assert property (
        gpe && |periph_enable_reg_in[1:0] |=> seg_lines_out == 4'h4) else $error("seg lines");
    // Main routes seen at least once.
    cover property (valid_out && target_out == 4'h5);
    cover property (valid_out && size_error_out);
    cover property (valid_out && target_out == 4'h3);
endmodule // mmd_asserts

bind mmd_decoder mmd_asserts mmd_asserts_inst (.*);
`default_nettype wire

// ==== verification/mmd_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Core side
// ----
module mmd_cpu_model (
    input wire logic sys_clk_in,
    output var logic req_out = 1'b0,
    output var logic [23:0] addr_out = 24'h0,
    output var logic fetch_out = 1'b0,
    output var logic write_out = 1'b0,
    output var logic byte_out = 1'b0
);
    // One access per call, held for one edge; a released address is inverted so none lingers.
    task automatic access(input logic [23:0] a, input logic f, w, b);
        @(posedge sys_clk_in);
        req_out <= 1'b1;
        addr_out <= a;
        fetch_out <= f;
        write_out <= w;
        byte_out <= b;
        @(posedge sys_clk_in);
        req_out <= 1'b0;
        addr_out <= ~a;
    endtask
endmodule // mmd_cpu_model
`default_nettype wire

// ==== verification/mmd_decoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Decoder bench
// ----
module mmd_decoder_test;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, bootstrap_in = 1'b0;
    logic bank0_busy_in = 1'b0, bank1_busy_in = 1'b0, req_in, fetch_in, write_in, byte_in;
    logic valid_out, external_out, size_error_out, bank_conflict_out, global_periph_enable_out;
    logic [23:0] addr_in;
    logic [15:0] system_config_reg_in = 16'h0, periph_enable_reg_in = 16'h0;
    logic [3:0] target_out, seg_lines_out;
    logic [1:0] width_out, wait_states_out;
    int err_total = 0, tests_run = 0;
    // Free running clock.
    always #4 sys_clk_in = ~sys_clk_in;
    mmd_decoder mmd_decoder_inst (.*);
    mmd_cpu_model mmd_cpu_model_inst (.sys_clk_in, .req_out(req_in), .addr_out(addr_in),
        .fetch_out(fetch_in), .write_out(write_in), .byte_out(byte_in));
    task automatic chk(input logic [23:0] s, e, input string n);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Kind bit 1 is fetch, bit 0 byte; the answer is judged once the edge has landed.
    task automatic go(input logic [23:0] a, input logic [1:0] k, input logic [3:0] t, w);
        mmd_cpu_model_inst.access(a, k[1], 1'b0, k[0]);
        #1;
        chk(valid_out, 1'b1, "valid");
        chk(target_out, t, "target");
        chk(external_out, t == 4'h0, "external");
        if (t != 4'h0)
            chk(width_out, w, "width");
    endtask
    task automatic t_flash;
        go(24'h000000, 2'h2, 4'h1, 4'h2);
        go(24'h007fff, 2'h0, 4'h1, 4'h1);
        go(24'h008000, 2'h0, 4'h0, 4'h0);
        go(24'h018000, 2'h1, 4'h1, 4'h1);
        go(24'h06ffff, 2'h0, 4'h1, 4'h1);
        go(24'h070000, 2'h0, 4'h2, 4'h1);
        go(24'h08ffff, 2'h2, 4'h2, 4'h2);
        go(24'h090000, 2'h0, 4'h0, 4'h0);
        go(24'h0e0000, 2'h0, 4'h4, 4'h1);
        @(posedge sys_clk_in) bootstrap_in <= 1'b1;
        go(24'h001ffe, 2'h2, 4'h3, 4'h2);
        go(24'h002000, 2'h0, 4'h1, 4'h1);
        @(posedge sys_clk_in) bootstrap_in <= 1'b0;
        $display("flash map done");
    endtask
    // Each window alone, its byte size flag, then every other window on but this one off.
    task automatic t_periph;
        logic [7:0] pg[8] = '{8'hef, 8'hee, 8'hed, 8'hec, 8'he9, 8'he8, 8'hea, 8'heb};
        int bt[8] = '{0, 1, 4, 6, 7, 8, 9, 10};
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_in) system_config_reg_in <= 16'h0004;
            periph_enable_reg_in <= 16'h0001 << bt[i];
            go({8'h00, pg[i], 8'hfe}, 2'h0, 4'h7 + i[3:0], 4'h1);
            chk(global_periph_enable_out, 1'b1, "gpe");
            chk(wait_states_out, 2'h2, "waits");
            chk(seg_lines_out, (i < 2) ? 4'h4 : 4'h8, "seg");
            go({8'h00, pg[i], 8'h01}, 2'h1, 4'h7 + i[3:0], 4'h1);
            chk(size_error_out, 1'b1, "size");
            @(posedge sys_clk_in) periph_enable_reg_in <= ~(16'h0001 << bt[i]);
            go({8'h00, pg[i], 8'h00}, 2'h0, 4'h0, 4'h0);
        end
        @(posedge sys_clk_in) system_config_reg_in <= 16'h0;
        go(24'h00ef00, 2'h0, 4'h0, 4'h0);
        chk(global_periph_enable_out, 1'b0, "gpe off");
        chk(seg_lines_out, 4'h8, "seg off");
        $display("windows done");
    endtask
    task automatic t_xram;
        @(posedge sys_clk_in) system_config_reg_in <= 16'h0004;
        periph_enable_reg_in <= 16'h000c;
        go(24'h00e7ff, 2'h1, 4'h5, 4'h1);
        chk(size_error_out | (|wait_states_out), 1'b0, "ram access");
        go(24'h0f7fff, 2'h0, 4'h6, 4'h1);
        @(posedge sys_clk_in) system_config_reg_in <= 16'h0;
        go(24'h00e000, 2'h0, 4'h0, 4'h0);
        go(24'h0f0000, 2'h0, 4'h0, 4'h0);
        @(posedge sys_clk_in) system_config_reg_in <= 16'h0004;
        periph_enable_reg_in <= 16'h0008;
        go(24'h00e000, 2'h0, 4'h0, 4'h0);
        go(24'h0f7fff, 2'h0, 4'h6, 4'h1);
        @(posedge sys_clk_in) periph_enable_reg_in <= 16'h0004;
        go(24'h0f0000, 2'h0, 4'h0, 4'h0);
        go(24'h00e000, 2'h0, 4'h5, 4'h1);
        $display("ram areas done");
    endtask
    task automatic t_bank;
        @(posedge sys_clk_in) bank0_busy_in <= 1'b1;
        go(24'h000000, 2'h0, 4'h1, 4'h1);
        chk(bank_conflict_out, 1'b1, "conflict");
        go(24'h070000, 2'h0, 4'h2, 4'h1);
        chk(bank_conflict_out, 1'b0, "conflict");
        mmd_cpu_model_inst.access(24'h000000, 1'b0, 1'b1, 1'b0);
        #1 chk(bank_conflict_out, 1'b0, "write");
        @(posedge sys_clk_in) bank0_busy_in <= 1'b0;
        bank1_busy_in <= 1'b1;
        go(24'h08fffe, 2'h2, 4'h2, 4'h2);
        chk(bank_conflict_out, 1'b1, "conflict");
        go(24'h06fffe, 2'h0, 4'h1, 4'h1);
        chk(bank_conflict_out, 1'b0, "conflict");
        $display("banks done");
    endtask
    // Reset for three edges, then the scenarios in turn.
    initial begin
        repeat (3) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        #1 chk(seg_lines_out, 4'h8, "seg reset");
        chk(valid_out, 1'b0, "valid reset");
        chk(target_out, 4'h0, "target reset");
        chk(global_periph_enable_out, 1'b0, "gpe reset");
        t_flash();
        t_periph();
        t_xram();
        t_bank();
        conclude();
    end
    // Some 130 cycles are needed; a stall far beyond that ends the run.
    initial begin
        #20000;
        err_total++;
        conclude();
    end
endmodule // mmd_decoder_test
`default_nettype wire
